// [verilog/fept_core.sv]
// 10/100 PHY timing core: MAC capture, line start, jabber, pulses, receive
//
// Contract
// [RULE1] 100M: carrier sense 20 bits, data 24 bits after J; bit is 10 ns
// [RULE2] 100M: carrier sense drops 24 bits after the T code group
// [RULE3] 10M nibble mode: capture data and enable on transmit clock fall
// [RULE4] MAC should launch nibble and enable from the transmit clock rise
// [RULE5] 10M serial mode: capture data bit and enable on clock rise
// [RULE6] Serial receive bit changes on receive clock fall, 50 ns phases
// [RULE7] Receive clock source switch may stretch a phase, never shorten
// [RULE8] 10BASE-T: drive line 3.5 bit times after first capture edge
// [RULE9] 10BASE-T: carrier sense 630 ns typical, 1000 ns max after activity
// [RULE10] 10BASE-T: receive valid 10 bits after first preamble bit
// [RULE11] 10M: jabber after 85 ms continuous transmit, release after 500 ms
// [RULE12] Idle 10BASE-T link sends 100 ns pulses every 16 ms
// [RULE13] Auto-negotiation bursts: 100 ns pulses, clock pulses 125 us apart
// [RULE14] Signal detect on after 1 ms present, off after 350 us lost
// [RULE15] Jabber suppresses line transmit and flags status until release
// [RULE16] All long timers count reference clock cycles
`timescale 1ns/1ns
module fept_core
  import fept_pkg::*;
#(
  parameter logic [fept_pkg::CNT_W-1:0] JAB_ON = fept_pkg::JAB_ON_CYC,
  parameter logic [fept_pkg::CNT_W-1:0] JAB_OFF = fept_pkg::JAB_OFF_CYC,
  parameter logic [fept_pkg::CNT_W-1:0] NLP_PER = fept_pkg::NLP_CYC,
  parameter logic [fept_pkg::CNT_W-1:0] SIG_ON = fept_pkg::SIG_ON_CYC,
  parameter logic [fept_pkg::CNT_W-1:0] SIG_OFF = fept_pkg::SIG_OFF_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic speed100_i,
  input wire logic serial_i,
  input wire logic autoneg_i,
  input wire logic flp_bit_i,
  input wire logic tx_clk_i,
  input wire logic tx_en_i,
  input wire logic [fept_pkg::NIB_W-1:0] txd_i,
  output logic tx_ready_o,
  output logic [fept_pkg::NIB_W-1:0] line_data_o,
  output logic line_valid_o,
  input wire logic line_ready_i,
  output logic line_drive_o,
  output logic link_pulse_o,
  output logic jabber_o,
  input wire logic rx_act_i,
  input wire logic rx_bit_i,
  input wire logic rx_src_i,
  input wire logic sig_i,
  output logic crs_o,
  output logic rx_dv_o,
  output logic rx_clk_o,
  output logic rx_data_o,
  output logic signal_present_flag_o
);
  import fept_pkg::*;

  localparam int SYN_W = 10;
  localparam int TX_DLY = int'(TX_DLY_CYC);

  typedef struct packed {
    logic [SYN_W-1:0] s1;
    logic [SYN_W-1:0] s2;
    logic txc_p;
    logic tx_act;
    logic [3:0] tx_ctr;
    logic drive;
    logic [CNT_W-1:0] jab_cnt;
    logic jabber;
    logic [CNT_W-1:0] lp_cnt;
    logic [1:0] lp_w;
    logic [4:0] rx_cnt;
    logic [2:0] off_cnt;
    logic crs;
    logic rx_dv;
    logic [CNT_W-1:0] sig_cnt;
    logic sig_pres;
    logic rxc;
    logic rx_src;
    logic rx_bit;
  } fept_st_t;

  fept_st_t q;
  fept_st_t d;
  logic txc_s, txen_s, act_s, sig_s, bit_s, src_s;
  logic [NIB_W-1:0] txd_s;
  logic rise, fall, cap_edge, cap;
  logic buf_in_rdy, buf_out_vld, buf_out_rdy;
  logic [NIB_W-1:0] cap_data;
  logic [4:0] on_cyc, dv_cyc;
  logic [2:0] off_cyc;
  logic [CNT_W-1:0] lp_per, sig_lim;

  // Second synchroniser stage, the only one logic reads
  assign {txc_s, txen_s, txd_s, act_s, sig_s, bit_s, src_s} = q.s2;
  assign rise = txc_s && !q.txc_p;
  assign fall = !txc_s && q.txc_p;
  assign cap_edge = serial_i ? rise : fall; // RULE3 RULE5
  assign cap = cap_edge && txen_s && !q.jabber && buf_in_rdy;
  assign cap_data = serial_i ? {3'h0, txd_s[0]} : txd_s;

  // Speed dependent receive limits, link pulse period and signal detect limit
  assign on_cyc = speed100_i ? CRS_ON_100_CYC : CRS_ON_10_CYC; // RULE1 RULE9
  assign dv_cyc = speed100_i ? RXD_100_CYC : RXDV_10_CYC; // RULE1 RULE10
  assign off_cyc = speed100_i ? CRS_OFF_100_CYC : CRS_OFF_10_CYC; // RULE2
  assign lp_per = autoneg_i ? FLP_CYC : NLP_PER; // RULE12 RULE13
  assign sig_lim = q.sig_pres ? SIG_OFF : SIG_ON; // RULE14

  // Jabber discards queued nibbles rather than stall
  assign buf_out_rdy = q.jabber || (q.drive && line_ready_i); // RULE15

  fept_buf2 #(
    .W(NIB_W)
  ) u_buf (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(cap),
    .in_ready_o(buf_in_rdy),
    .in_data_i(cap_data),
    .out_valid_o(buf_out_vld),
    .out_ready_i(buf_out_rdy),
    .out_data_o(line_data_o)
  );

  // Outputs
  assign tx_ready_o = buf_in_rdy;
  assign line_valid_o = buf_out_vld && q.drive && !q.jabber; // RULE15
  assign line_drive_o = q.drive && !q.jabber; // RULE15
  assign jabber_o = q.jabber; // RULE15
  assign link_pulse_o = (q.lp_w != 2'h0);
  assign crs_o = q.crs;
  assign rx_dv_o = q.rx_dv;
  assign rx_clk_o = q.rxc;
  assign rx_data_o = q.rx_bit;
  assign signal_present_flag_o = q.sig_pres;

  // Next state
  always_comb begin
    d = q;
    d.s1 = {tx_clk_i, tx_en_i, txd_i, rx_act_i, sig_i, rx_bit_i, rx_src_i};
    d.s2 = q.s1;
    d.txc_p = txc_s;
    // Transmit activity follows enable at each capture edge
    if (cap_edge) begin
      d.tx_act = txen_s;
      if (txen_s && !q.tx_act) begin
        d.tx_ctr = speed100_i ? 4'h1 : TX_DLY_CYC; // RULE8
      end
    end
    if (q.tx_ctr != 4'h0) begin
      d.tx_ctr = q.tx_ctr - 4'h1;
      if (q.tx_ctr == 4'h1) begin
        d.drive = 1'b1; // RULE8
      end
    end else if (!q.tx_act && !buf_out_vld) begin
      d.drive = 1'b0;
    end
    // Jabber timers in system clock cycles
    if (q.jabber) begin
      d.jab_cnt = q.jab_cnt + 24'h000001; // RULE16
      if (q.jab_cnt == JAB_OFF - 24'h000001) begin
        d.jabber = 1'b0; // RULE11 RULE15
        d.jab_cnt = '0;
      end
    end else if (q.tx_act && !speed100_i) begin
      d.jab_cnt = q.jab_cnt + 24'h000001;
      if (q.jab_cnt == JAB_ON - 24'h000001) begin
        d.jabber = 1'b1; // RULE11
        d.jab_cnt = '0;
      end
    end else begin
      d.jab_cnt = '0;
    end
    // Normal and fast link pulses
    if (q.lp_w != 2'h0) begin
      d.lp_w = q.lp_w - 2'h1;
    end
    if (autoneg_i || (!speed100_i && !q.tx_act)) begin
      d.lp_cnt = q.lp_cnt + 24'h000001; // RULE16
      if (q.lp_cnt == lp_per - 24'h000001) begin
        d.lp_cnt = '0;
        d.lp_w = PULSE_CYC; // RULE12 RULE13
      end else if (autoneg_i && flp_bit_i && q.lp_cnt == (lp_per >> 1)) begin
        d.lp_w = PULSE_CYC; // RULE13
      end
    end else begin
      d.lp_cnt = '0;
    end
    // Carrier sense and receive valid from line activity
    if (act_s) begin
      d.off_cnt = '0;
      if (q.rx_cnt != 5'h1F) begin
        d.rx_cnt = q.rx_cnt + 5'h01;
      end
      if (q.rx_cnt == on_cyc - 5'h01) begin
        d.crs = 1'b1; // RULE1 RULE9
      end
      if (q.rx_cnt == dv_cyc - 5'h01) begin
        d.rx_dv = 1'b1; // RULE10
      end
    end else begin
      d.rx_cnt = '0;
      if (q.crs || q.rx_dv) begin
        d.off_cnt = q.off_cnt + 3'h1;
        if (q.off_cnt == off_cyc - 3'h1) begin
          d.crs = 1'b0; // RULE2
          d.rx_dv = 1'b0;
          d.off_cnt = '0;
        end
      end
    end
    // Signal detect filter
    if (sig_s != q.sig_pres) begin
      d.sig_cnt = q.sig_cnt + 24'h000001; // RULE16
      if (q.sig_cnt == sig_lim - 24'h000001) begin
        d.sig_pres = sig_s; // RULE14
        d.sig_cnt = '0;
      end
    end else begin
      d.sig_cnt = '0;
    end
    // Receive clock; a source change holds the current phase once
    if (src_s != q.rx_src) begin
      d.rx_src = src_s; // RULE7
    end else begin
      d.rxc = ~q.rxc; // RULE6
      if (q.rxc) begin
        d.rx_bit = bit_s; // RULE6
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  sequence s_tx_start;
    $rose(q.tx_act) && !speed100_i && !q.jabber;
  endsequence

  property p_tx_dly;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_tx_start |-> ##TX_DLY q.drive;
  endproperty
  a_tx_dly: assert property (p_tx_dly) // RULE8
    else $error("line drive not on time after first capture");

  property p_cap_edge;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    cap |-> (serial_i ? rise : fall);
  endproperty
  a_cap_edge: assert property (p_cap_edge) // RULE3 RULE5
    else $error("nibble captured on wrong clock edge");

  property p_jab_sup;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    q.jabber |-> !line_valid_o && !line_drive_o && jabber_o;
  endproperty
  a_jab_sup: assert property (p_jab_sup) // RULE15
    else $error("transmit not suppressed during jabber");

  property p_jab_on;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(q.jabber) |-> $past(q.tx_act) && !speed100_i;
  endproperty
  a_jab_on: assert property (p_jab_on) // RULE11
    else $error("jabber without transmit");

  property p_pulse_w;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(link_pulse_o) |-> link_pulse_o ##1 link_pulse_o ##1 !link_pulse_o;
  endproperty
  a_pulse_w: assert property (p_pulse_w) // RULE12 RULE13
    else $error("link pulse width wrong");

  property p_rx_fall;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $changed(rx_data_o) |-> $fell(rx_clk_o);
  endproperty
  a_rx_fall: assert property (p_rx_fall) // RULE6
    else $error("receive bit moved off the clock fall");

  property p_rxc_stretch;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $stable(rx_clk_o) |=> $changed(rx_clk_o);
  endproperty
  a_rxc_stretch: assert property (p_rxc_stretch) // RULE7
    else $error("receive clock phase stretched too far");

  property p_crs_on;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(crs_o) |-> $past(act_s) && $past(q.rx_cnt) == on_cyc - 5'h01;
  endproperty
  a_crs_on: assert property (p_crs_on) // RULE1 RULE9
    else $error("carrier sense rose at wrong latency");

  property p_sig_pres;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $changed(q.sig_pres) |-> q.sig_pres == $past(sig_s);
  endproperty
  a_sig_pres: assert property (p_sig_pres) // RULE14
    else $error("signal detect moved against the line");
endmodule : fept_core

// [verilog/fept_pkg.sv]
// Constants shared by the PHY timing core and its testbench
package fept_pkg;
  // System clock
  localparam int CLK_NS = 50;
  localparam int CNT_W = 24;
  localparam int NIB_W = 4;
  // Bit times
  localparam int BIT100_NS = 10;
  localparam int BIT10_NS = 100;
  // 100BASE-TX receive latencies in bit times
  localparam int CRS_ON_100_BITS = 20;
  localparam int RXD_100_BITS = 24;
  localparam int CRS_OFF_100_BITS = 24;
  localparam logic [4:0] CRS_ON_100_CYC =
    5'((CRS_ON_100_BITS * BIT100_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] RXD_100_CYC =
    5'((RXD_100_BITS * BIT100_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] CRS_OFF_100_CYC =
    3'((CRS_OFF_100_BITS * BIT100_NS + CLK_NS - 1) / CLK_NS);
  // 10BASE-T receive latencies
  localparam int CRS_ON_10_NS = 630;
  localparam int RXDV_10_BITS = 10;
  localparam logic [4:0] CRS_ON_10_CYC =
    5'((CRS_ON_10_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] RXDV_10_CYC =
    5'((RXDV_10_BITS * BIT10_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] CRS_OFF_10_CYC = 3'h1;
  // 10BASE-T transmit start, 3.5 bit times held in tenths
  localparam int TX_DLY_TENTHS = 35;
  localparam logic [3:0] TX_DLY_CYC =
    4'((TX_DLY_TENTHS * BIT10_NS / 10 + CLK_NS - 1) / CLK_NS);
  // Jabber timers
  localparam int JAB_ON_MS = 85;
  localparam int JAB_OFF_MS = 500;
  localparam logic [CNT_W-1:0] JAB_ON_CYC =
    CNT_W'(JAB_ON_MS * 1000000 / CLK_NS);
  localparam logic [CNT_W-1:0] JAB_OFF_CYC =
    CNT_W'(JAB_OFF_MS * 1000000 / CLK_NS);
  // Link pulses
  localparam int PULSE_NS = 100;
  localparam int NLP_MS = 16;
  localparam int FLP_US = 125;
  localparam logic [1:0] PULSE_CYC = 2'(PULSE_NS / CLK_NS);
  localparam logic [CNT_W-1:0] NLP_CYC = CNT_W'(NLP_MS * 1000000 / CLK_NS);
  localparam logic [CNT_W-1:0] FLP_CYC = CNT_W'(FLP_US * 1000 / CLK_NS);
  // Signal detect filter
  localparam int SIG_ON_MS = 1;
  localparam int SIG_OFF_US = 350;
  localparam logic [CNT_W-1:0] SIG_ON_CYC =
    CNT_W'(SIG_ON_MS * 1000000 / CLK_NS);
  localparam logic [CNT_W-1:0] SIG_OFF_CYC =
    CNT_W'(SIG_OFF_US * 1000 / CLK_NS);
endpackage : fept_pkg

// [verilog/fept_buf2.sv]
// Two-entry valid/ready buffer for transmit nibbles
`timescale 1ns/1ns
module fept_buf2 #(
  parameter int W = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } fept_buf_t;

  fept_buf_t q;
  fept_buf_t d;

  // Honest full and empty flags
  assign in_ready_o = (q.cnt != 2'h2);
  assign out_valid_o = (q.cnt != 2'h0);
  assign out_data_o = q.mem[q.rp];

  // Push and pop bookkeeping
  always_comb begin
    d = q;
    if (in_valid_i && in_ready_o) begin
      d.mem[q.wp] = in_data_i;
      d.wp = ~q.wp;
    end
    if (out_valid_o && out_ready_i) begin
      d.rp = ~q.rp;
    end
    d.cnt = 2'(q.cnt + {1'b0, in_valid_i && in_ready_o}
      - {1'b0, out_valid_o && out_ready_i});
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : fept_buf2

// [tb/fept_mac_model.sv]
// Behavioural MAC transmit side with its own link clock
`timescale 1ns/1ns
module fept_mac_model (
  output logic tx_clk_o,
  output logic tx_en_o,
  output logic [3:0] txd_o
);
  // Link clock stands still low outside frames
  initial begin
    tx_clk_o = 1'b0;
    tx_en_o = 1'b0;
    txd_o = 4'h0;
  end
  // One link clock period carrying one unit
  task send(input logic [3:0] nib, input logic ser, input logic en);
    if (!ser) begin
      tx_clk_o = 1'b1;
      tx_en_o = en;
      txd_o = nib;
      #200 tx_clk_o = 1'b0;
      #200;
    end else begin
      tx_en_o = en;
      txd_o = nib;
      #200 tx_clk_o = 1'b1;
      #200 tx_clk_o = 1'b0;
    end
  endtask : send
  // Closing period with enable low, then data lines no longer hold
  task finish(input logic ser);
    send(~txd_o, ser, 1'b0);
    txd_o = ~txd_o;
  endtask : finish
endmodule : fept_mac_model

// [tb/tb_top.sv]
// Self-checking bench for the PHY timing core
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
  num_errors++; $display("Error %s expected %0h seen %0h", nm, ex, got); \
  end end
module tb_top;
  import fept_pkg::*;
  localparam int JON = 200;
  localparam int JOFF = 100;
  localparam int NLP = 50;
  localparam int SDN = 20;
  localparam int SDF = 10;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic speed100_i = 1'b0;
  logic serial_i = 1'b0;
  logic autoneg_i = 1'b0;
  logic flp_bit_i = 1'b0;
  logic tx_clk_i, tx_en_i, tx_ready_o, line_valid_o, line_drive_o;
  logic [3:0] txd_i, line_data_o, e;
  logic line_ready_i = 1'b0;
  logic link_pulse_o, jabber_o, crs_o, rx_dv_o, rx_clk_o, rx_data_o;
  logic signal_present_flag_o;
  logic rx_act_i = 1'b0;
  logic rx_bit_i = 1'b0;
  logic rx_src_i = 1'b0;
  logic sig_i = 1'b0;
  logic [1:0] rdy_mode = 2'h2;
  logic [31:0] st = 32'h9EF007B4;
  logic sb_on = 1'b1;
  logic pclk = 1'b0;
  logic pdat = 1'b0;
  logic [2:0] bh = 3'h0;
  int up = 0;
  logic [3:0] exp_q[$];
  int checks = 0;
  int num_errors = 0;
  int run = 0;
  real t0, drv_t;

  always #25 clk_sys_i = ~clk_sys_i;

  fept_core #(.JAB_ON(CNT_W'(JON)), .JAB_OFF(CNT_W'(JOFF)),
    .NLP_PER(CNT_W'(NLP)), .SIG_ON(CNT_W'(SDN)), .SIG_OFF(CNT_W'(SDF))
  ) u_fept_core (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .speed100_i(speed100_i), .serial_i(serial_i), .autoneg_i(autoneg_i),
    .flp_bit_i(flp_bit_i), .tx_clk_i(tx_clk_i), .tx_en_i(tx_en_i),
    .txd_i(txd_i), .tx_ready_o(tx_ready_o), .line_data_o(line_data_o),
    .line_valid_o(line_valid_o), .line_ready_i(line_ready_i),
    .line_drive_o(line_drive_o), .link_pulse_o(link_pulse_o),
    .jabber_o(jabber_o), .rx_act_i(rx_act_i), .rx_bit_i(rx_bit_i),
    .rx_src_i(rx_src_i), .sig_i(sig_i), .crs_o(crs_o), .rx_dv_o(rx_dv_o),
    .rx_clk_o(rx_clk_o), .rx_data_o(rx_data_o),
    .signal_present_flag_o(signal_present_flag_o));

  fept_mac_model u_fept_mac_model (.tx_clk_o(tx_clk_i), .tx_en_o(tx_en_i),
    .txd_o(txd_i));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Random state, random receive inputs and line side readiness
  always @(posedge clk_sys_i) begin
    st <= lfsr(st);
    rx_bit_i <= st[4];
    // Source toggles never on two edges in a row
    rx_src_i <= (st[15:12] == 4'hA) ? ~rx_src_i : rx_src_i;
    line_ready_i <= rdy_mode[1] ? (st[2] | st[9]) : rdy_mode[0];
  end

  // Scoreboard on nibbles taken by the line side
  always @(negedge clk_sys_i) begin
    if (sb_on && line_valid_o === 1'b1 && line_ready_i === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : ~line_data_o;
      `CHK("line data", e, line_data_o)
    end
  end

  // Receive clock phases, data edges and jabber blanking
  always @(negedge clk_sys_i) begin
    if (rst_n_i === 1'b1) begin
      if (rx_clk_o !== pclk) begin
        `CHK("rx clock phase", 1'b1, run <= 2)
        run = 1;
      end else run++;
      if (rx_data_o !== pdat) `CHK("rx data edge", 2'h2, {pclk, rx_clk_o})
      if (up > 4 && {pclk, rx_clk_o} === 2'h2)
        `CHK("rx data", bh[2], rx_data_o)
      if (jabber_o === 1'b1) `CHK("valid in jabber", 1'b0, line_valid_o)
      up++;
    end
    pclk = rx_clk_o;
    pdat = rx_data_o;
    bh = {bh[1:0], rx_bit_i};
  end

  // Moment the line starts being driven
  always @(posedge line_drive_o) drv_t = $realtime;

  function automatic logic pick(input int sel);
    case (sel)
      0: return crs_o;
      1: return rx_dv_o;
      2: return jabber_o;
      3: return link_pulse_o;
      default: return signal_present_flag_o;
    endcase
  endfunction : pick

  // Count negative edges until a watched output shows a level
  task wcnt(input int sel, input logic lvl, output int n);
    n = 0;
    while (pick(sel) !== lvl && n < 4000) begin
      @(negedge clk_sys_i);
      n++;
    end
  endtask : wcnt

  task win(input string nm, input int n, input int lo, input int hi);
    `CHK(nm, 1'b1, n >= lo && n <= hi)
  endtask : win

  // One transmit frame; the first keep units are expected on the line
  task frame(input int cnt, input logic ser, input int keep,
    input logic fast);
    logic [3:0] nib;
    int dly;
    dly = fast ? 1 : int'(TX_DLY_CYC);
    @(posedge clk_sys_i);
    serial_i <= ser;
    speed100_i <= fast;
    @(posedge clk_sys_i);
    #17 t0 = $realtime;
    drv_t = 0.0;
    for (int i = 0; i < cnt; i++) begin
      nib = st[7:4] ^ 4'(i);
      if (i < keep) exp_q.push_back(ser ? {3'h0, nib[0]} : nib);
      u_fept_mac_model.send(nib, ser, 1'b1);
    end
    u_fept_mac_model.finish(ser);
    win("line start", $rtoi((drv_t - t0 - 200.0) / 50.0), dly + 2,
      dly + 5);
  endtask : frame

  task drain();
    repeat (60) @(posedge clk_sys_i);
    `CHK("units left", 0, exp_q.size())
  endtask : drain

  // Carrier and receive valid on, then off
  task rx_case(input logic fast, input int on, input int dv, input int off);
    int n, m;
    @(posedge clk_sys_i);
    speed100_i <= fast;
    repeat (4) @(posedge clk_sys_i);
    rx_act_i <= 1'b1;
    wcnt(0, 1'b1, n);
    win("carrier on", n, on, on + 4);
    wcnt(1, 1'b1, m);
    win("receive valid", n + m, dv, dv + 4);
    @(posedge clk_sys_i);
    rx_act_i <= 1'b0;
    wcnt(0, 1'b0, n);
    win("carrier off", n, off, off + 4);
    @(negedge clk_sys_i);
    `CHK("valid off", 1'b0, rx_dv_o)
  endtask : rx_case

  // Pulse width and the gap to the next pulse
  task pulse_gap(output int n);
    int w;
    wcnt(3, 1'b1, w);
    wcnt(3, 1'b0, w);
    win("pulse width", w, 2, 2);
    wcnt(3, 1'b1, n);
    n = n + 2;
  endtask : pulse_gap

  task conclude();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // Watchdog
  initial begin
    #2000000;
    num_errors++;
    conclude();
  end

  // Main sequence
  initial begin
    int n;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    frame(6, 1'b0, 6, 1'b0);
    drain();
    frame(6, 1'b1, 6, 1'b0);
    drain();
    frame(4, 1'b0, 4, 1'b1);
    drain();
    rdy_mode <= 2'h0;
    frame(4, 1'b0, 2, 1'b0);
    `CHK("buffer refuses", 1'b0, tx_ready_o)
    `CHK("held nibble", 1'b1, line_valid_o)
    rdy_mode <= 2'h2;
    drain();
    rx_case(1'b1, CRS_ON_100_CYC, RXD_100_CYC, CRS_OFF_100_CYC);
    rx_case(1'b0, CRS_ON_10_CYC, RXDV_10_CYC, CRS_OFF_10_CYC);
    sig_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    sig_i <= 1'b0;
    repeat (30) @(negedge clk_sys_i);
    `CHK("short signal", 1'b0, signal_present_flag_o)
    @(posedge clk_sys_i);
    sig_i <= 1'b1;
    wcnt(4, 1'b1, n);
    win("detect on", n, SDN, SDN + 5);
    @(posedge clk_sys_i);
    sig_i <= 1'b0;
    wcnt(4, 1'b0, n);
    win("detect off", n, SDF, SDF + 5);
    sb_on = 1'b0;
    rdy_mode <= 2'h1;
    @(posedge clk_sys_i);
    #17 t0 = $realtime;
    for (int i = 0; i < 60 && jabber_o !== 1'b1; i++)
      u_fept_mac_model.send(st[3:0], 1'b0, 1'b1);
    win("jabber on", $rtoi(($realtime - t0) / 50.0), JON, JON + 20);
    u_fept_mac_model.finish(1'b0);
    wcnt(2, 1'b0, n);
    win("jabber off", n, JOFF - 20, JOFF + 10);
    repeat (40) @(posedge clk_sys_i);
    sb_on = 1'b1;
    rdy_mode <= 2'h2;
    pulse_gap(n);
    pulse_gap(n);
    win("idle pulse period", n, NLP - 1, NLP + 1);
    @(posedge clk_sys_i);
    autoneg_i <= 1'b1;
    pulse_gap(n);
    pulse_gap(n);
    win("burst clock spacing", n, FLP_CYC - 1, FLP_CYC + 1);
    @(posedge clk_sys_i);
    flp_bit_i <= 1'b1;
    pulse_gap(n);
    pulse_gap(n);
    win("data pulse spacing", n, FLP_CYC / 2 - 1, FLP_CYC / 2 + 1);
    conclude();
  end
endmodule : tb_top
